// ### rtl/cc_clock_ctrl.sv
// Output source select, frequency control, timer and power gating.
// Assumes source ticks and pins are synchronous to clk; cfg_stage
// holds bytes staged by the serial port, applied on cfg_stop.
//
// Contract
// RULE1: Single-ended source from four select bits: 32k, THIRD_PLL/5, SECOND_PLL/4, ref/4.
// RULE2: Differential source: own bit gives SECOND_PLL/3, shared bit ref/1, else FIRST_PLL/1.
// RULE3: Control off gives selection 0; pin function select gives {0,pin}.
// RULE4: Control on, latched clock pin low: selection from clock and data pins.
// RULE5: Control on, latched clock pin high: selection from register field.
// RULE6: Four stored settings; setting steps toward target without overshoot.
// RULE7: Pin level change yields glitch-free output frequency change.
// RULE8: Config index chooses which stored setting receives setting writes.
// RULE9: Monitor function: end device down moves single-ended output to 32k.
// RULE10: Software writes code 10 to pin function field to pick monitor.
// RULE11: Timer offers 0.5, 1, 2 or 4 second intervals by two bits.
// RULE12: Timer expiry sets flag; timer enable written 0 clears it.
// RULE13: Expiry with reset control enabled drives 250 ms reset pulse.
// RULE14: Expiry with control on returns to first setting, then disables control.
// RULE15: Pin functions: output enable, power-down, monitor, select bit, reset.
// RULE16: Output enable function gates only the single-ended output.
// RULE17: Pin power-down low stops all outputs except enabled 32k output.
// RULE18: Output runs only with power-down inactive, global and own enables.
// RULE19: Register power-down keeps serial port alive; ultra turns all off.
// RULE20: Block write bytes apply together only after STOP.
// RULE21: Stopped outputs sit low; start and stop on whole periods only.
`default_nettype none
`include "cc_regs.svh"
module cc_clock_ctrl #(
  parameter int CYC_PER_MS = `CC_CYC_PER_MS,
  parameter int SET_W      = 32
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire cc_pkg::cc_cfg_t   cfg_stage,
  input  wire logic              cfg_stop,
  input  wire logic              vco_wr,
  input  wire logic [SET_W-1:0]  vco_wdata,
  input  wire cc_pkg::cc_ticks_t src_ticks,
  input  wire logic              mf_pin_i,
  output logic                   mf_pin_o,
  output logic                   mf_pin_oe,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   single_ended_output,
  output logic                   differential_output_a,
  output logic                   differential_output_b,
  output logic                   timeout_flag,
  output cc_pkg::cc_pwr_t        pwr_state,
  output logic                   i2c_active,
  output logic [1:0]             freq_sel,
  output logic [SET_W-1:0]       vco_setting,
  output logic                   slewing
);
  localparam int MS_W = 13;
  localparam int PS_W = $clog2(CYC_PER_MS + 1);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic pick_tick(cc_pkg::cc_src_t s,
                                     cc_pkg::cc_ticks_t t);
    logic r;
    r = 1'b0;
    unique case (s)
      cc_pkg::CC_SRC_NONE: r = 1'b0;
      cc_pkg::CC_SRC_OSC:  r = t.osc32k;
      cc_pkg::CC_SRC_FIRST_PLL: r = t.first_pll;
      cc_pkg::CC_SRC_SECOND_PLL: r = t.second_pll;
      cc_pkg::CC_SRC_THIRD_PLL: r = t.third_pll;
      cc_pkg::CC_SRC_REF:  r = t.ref_clk;
      default:             r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [5:0] diff_route(logic own, logic shared);
    logic [5:0] r;
    if (shared) begin
      r = {cc_pkg::CC_SRC_REF, `CC_DIV_DIFF_REF};
    end else if (own) begin
      r = {cc_pkg::CC_SRC_SECOND_PLL, `CC_DIV_DIFF_SECOND_PLL};
    end else begin
      r = {cc_pkg::CC_SRC_FIRST_PLL, `CC_DIV_DIFF_FIRST_PLL};
    end
    return r;
  endfunction

  // ****************************************
  // Staged configuration
  // ****************************************
  cc_pkg::cc_cfg_t  cfg_r;
  logic             pend_r;
  logic [SET_W-1:0] pend_data_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= '0;
    end else if (cfg_stop) begin
      cfg_r <= cfg_stage; // RULE20
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r      <= 1'b0;
      pend_data_r <= '0;
    end else if (cfg_stop) begin
      pend_r <= 1'b0;
    end else if (vco_wr) begin
      pend_r      <= 1'b1;
      pend_data_r <= vco_wdata;
    end
  end

  // Selection pin caught once after reset release
  logic arm_r;
  logic sel_latch_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      arm_r       <= 1'b1;
      sel_latch_r <= 1'b1;
    end else if (arm_r) begin
      arm_r       <= 1'b0;
      sel_latch_r <= scl_i;
    end
  end

  // ****************************************
  // Frequency selection
  // ****************************************
  logic       kill_r;
  logic       fce_eff;
  logic       expire;
  logic [1:0] fsel_nxt;
  cc_pkg::cc_pin_fn_t fn;

  assign fn      = cfg_r.enable_pin_function_field;
  assign fce_eff = cfg_r.freq_control_enable & ~kill_r;

  always_comb begin
    if (!fce_eff) begin
      fsel_nxt = 2'h0; // RULE3 RULE14
    end else if (fn == cc_pkg::CC_FN_FSEL && !cfg_r.reset_pin_sel) begin
      fsel_nxt = {1'b0, mf_pin_i}; // RULE3 RULE15
    end else if (!sel_latch_r) begin
      fsel_nxt = {scl_i, sda_i}; // RULE4
    end else begin
      fsel_nxt = cfg_r.freq_sel_reg; // RULE5
    end
  end

  assign freq_sel = fsel_nxt;

  // Stays off until software drops the enable
  always_ff @(posedge clk) begin
    if (rst || !cfg_r.freq_control_enable) begin
      kill_r <= 1'b0;
    end else if (expire) begin
      kill_r <= 1'b1; // RULE14
    end
  end

  // ****************************************
  // Stored settings and slew
  // ****************************************
  logic [SET_W-1:0] target;
  logic [SET_W-1:0] cur_r;
  logic [4:0]       slew_div_r;
  logic             slew_tick;

  cc_setting_mem #(.W(SET_W), .DEPTH(4), .AW(2)) u_mem (
    .clk   (clk),
    .rst   (rst),
    .we    (pend_r & cfg_stop), // RULE8 RULE20
    .waddr (cfg_r.cfg_index), // RULE8
    .wdata (pend_data_r),
    .raddr (fsel_nxt), // RULE6
    .rdata (target)
  );

  always_ff @(posedge clk) begin
    if (rst || slew_tick) begin
      slew_div_r <= '0;
    end else begin
      slew_div_r <= slew_div_r + 5'h1;
    end
  end
  assign slew_tick = slew_div_r == 5'(`CC_SLEW_DIV - 1);

  // Bounded steps keep the loop locked; the last step lands exactly
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_r <= SET_W'(`CC_SETTING_RST);
    end else if (slew_tick && cur_r != target) begin
      if (target > cur_r) begin
        cur_r <= (target - cur_r > `CC_SLEW_STEP) ?
                 cur_r + `CC_SLEW_STEP : target; // RULE6 RULE7
      end else begin
        cur_r <= (cur_r - target > `CC_SLEW_STEP) ?
                 cur_r - `CC_SLEW_STEP : target; // RULE6 RULE7
      end
    end
  end
  assign vco_setting = cur_r;
  assign slewing     = cur_r != target;

  // ****************************************
  // Timer
  // ****************************************
  logic [PS_W-1:0] ps_r;
  logic            ms_tick;
  logic [MS_W-1:0] ms_r;
  logic [MS_W-1:0] lim;
  logic [MS_W-1:0] pulse_r;
  logic            flag_r;

  always_ff @(posedge clk) begin
    if (rst || ms_tick) begin
      ps_r <= '0;
    end else begin
      ps_r <= ps_r + PS_W'(1);
    end
  end
  assign ms_tick = ps_r == PS_W'(CYC_PER_MS - 1);

  always_comb begin
    unique case (cfg_r.timer_sel)
      2'h0: lim = MS_W'(`CC_TMO_SEL0_MS); // RULE11
      2'h1: lim = MS_W'(`CC_TMO_SEL1_MS);
      2'h2: lim = MS_W'(`CC_TMO_SEL2_MS);
      2'h3: lim = MS_W'(`CC_TMO_SEL3_MS);
    endcase
  end

  assign expire = cfg_r.timer_en & ~flag_r & ms_tick &
                  (ms_r == lim - MS_W'(1));

  always_ff @(posedge clk) begin
    if (rst || !cfg_r.timer_en || flag_r) begin
      ms_r <= '0;
    end else if (ms_tick) begin
      ms_r <= ms_r + MS_W'(1);
    end
  end

  // Expiry needs the enable, so set and clear never meet
  always_ff @(posedge clk) begin
    if (rst || !cfg_r.timer_en) begin
      flag_r <= 1'b0; // RULE12
    end else if (expire) begin
      flag_r <= 1'b1; // RULE12
    end
  end
  assign timeout_flag = flag_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_r <= '0;
    end else if (expire && cfg_r.reset_ctl_en) begin
      pulse_r <= MS_W'(`CC_RST_PULSE_MS); // RULE13
    end else if (ms_tick && pulse_r != '0) begin
      pulse_r <= pulse_r - MS_W'(1);
    end
  end

  assign mf_pin_oe = cfg_r.reset_pin_sel; // RULE15
  assign mf_pin_o  = cfg_r.reset_pin_sel & (pulse_r != '0); // RULE13

  // ****************************************
  // Power and output gating
  // ****************************************
  logic       pin_in_use;
  logic       pin_pd;
  logic       mon_down;
  logic [5:0] se_route;
  logic [5:0] route [3];
  logic [2:0] want;
  logic [2:0] run_r;
  logic [2:0] out_r;
  logic [2:0] cnt_r [3];

  assign pin_in_use = ~cfg_r.reset_pin_sel;
  assign pin_pd     = pin_in_use & fn == cc_pkg::CC_FN_PWRDN & ~mf_pin_i;
  assign mon_down   = pin_in_use & fn == cc_pkg::CC_FN_MONITOR & ~mf_pin_i;

  always_comb begin
    if (cfg_r.ultra_powerdown) begin
      pwr_state = cc_pkg::CC_PWR_ULTRA; // RULE19
    end else if (cfg_r.reg_powerdown) begin
      pwr_state = cc_pkg::CC_PWR_REG; // RULE19
    end else if (pin_pd) begin
      pwr_state = cc_pkg::CC_PWR_PIN; // RULE17
    end else begin
      pwr_state = cc_pkg::CC_PWR_FULL;
    end
  end
  assign i2c_active = ~cfg_r.ultra_powerdown; // RULE19

  always_comb begin
    if (mon_down) begin
      se_route = {cc_pkg::CC_SRC_OSC, `CC_DIV_SE_OSC}; // RULE9
    end else begin
      unique case (cfg_r.se_sel)
        `CC_SE_OSC32K: se_route = {cc_pkg::CC_SRC_OSC, `CC_DIV_SE_OSC};
        `CC_SE_THIRD_PLL:   se_route = {cc_pkg::CC_SRC_THIRD_PLL, `CC_DIV_SE_THIRD_PLL};
        `CC_SE_SECOND_PLL:   se_route = {cc_pkg::CC_SRC_SECOND_PLL, `CC_DIV_SE_SECOND_PLL};
        `CC_SE_REF:    se_route = {cc_pkg::CC_SRC_REF, `CC_DIV_SE_REF};
        default:       se_route = {cc_pkg::CC_SRC_NONE, 3'h1};
      endcase // RULE1
    end
  end

  assign route[0] = se_route;
  assign route[1] = diff_route(cfg_r.diff_a_second_pll, cfg_r.diff_ref); // RULE2
  assign route[2] = diff_route(cfg_r.diff_b_second_pll, cfg_r.diff_ref); // RULE2

  always_comb begin
    logic base;
    logic se_32k;
    base   = ~cfg_r.ultra_powerdown & ~cfg_r.reg_powerdown &
             cfg_r.i2c_oe_en; // RULE18 RULE19
    se_32k = route[0][5:3] == cc_pkg::CC_SRC_OSC;
    want   = base ? cfg_r.out_en : 3'h0; // RULE18
    if (pin_pd) begin
      want = {2'h0, want[0] & se_32k}; // RULE17
    end
    if (pin_in_use && fn == cc_pkg::CC_FN_OUT_EN && !mf_pin_i) begin
      want[0] = 1'b0; // RULE16
    end
  end

  // Run state only moves while the output sits low
  for (genvar i = 0; i < 3; i++) begin : g_out
    always_ff @(posedge clk) begin
      if (rst) begin
        run_r[i] <= 1'b0;
      end else if (!out_r[i]) begin
        run_r[i] <= want[i]; // RULE21
      end
    end

    always_ff @(posedge clk) begin
      if (rst || !run_r[i]) begin
        cnt_r[i] <= '0;
        out_r[i] <= 1'b0; // RULE21
      end else if (pick_tick(cc_pkg::cc_src_t'(route[i][5:3]),
                             src_ticks)) begin
        if (cnt_r[i] >= route[i][2:0] - 3'h1) begin
          cnt_r[i] <= '0;
          out_r[i] <= ~out_r[i]; // RULE1 RULE2 RULE7
        end else begin
          cnt_r[i] <= cnt_r[i] + 3'h1;
        end
      end
    end
  end

  assign single_ended_output   = out_r[0];
  assign differential_output_a = out_r[1];
  assign differential_output_b = out_r[2];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence pulse_start_s;
    expire && cfg_r.reset_ctl_en && cfg_r.reset_pin_sel;
  endsequence
  sequence pulse_hold_s;
    mf_pin_o [*8];
  endsequence

  fsel_off_a: assert property (!cfg_r.freq_control_enable |-> // RULE3
    freq_sel == 2'h0) else $error("selection not zero when off");
  fsel_pin_a: assert property (fce_eff && fn == cc_pkg::CC_FN_FSEL && // RULE3
    !cfg_r.reset_pin_sel |-> freq_sel == {1'b0, mf_pin_i})
    else $error("pin selection wrong");
  fsel_pins_a: assert property (fce_eff && fn != cc_pkg::CC_FN_FSEL && // RULE4
    !sel_latch_r && !arm_r |-> freq_sel == {scl_i, sda_i})
    else $error("serial pin selection wrong");
  fsel_reg_a: assert property (fce_eff && fn != cc_pkg::CC_FN_FSEL && // RULE5
    sel_latch_r && !arm_r |-> freq_sel == cfg_r.freq_sel_reg)
    else $error("register selection wrong");
  slew_step_a: assert property ($changed(cur_r) |-> // RULE6
    (cur_r > $past(cur_r) ? cur_r - $past(cur_r) : $past(cur_r) - cur_r)
    <= `CC_SLEW_STEP) else $error("setting step too large");
  flag_clear_a: assert property (!cfg_r.timer_en |=> // RULE12
    !timeout_flag) else $error("flag not cleared");
  flag_set_a: assert property (expire |=> timeout_flag) // RULE12
    else $error("flag not set on expiry");
  rst_pulse_a: assert property (pulse_start_s |=> pulse_hold_s) // RULE13
    else $error("reset pulse too short");
  kill_sel_a: assert property (expire && cfg_r.freq_control_enable |=> // RULE14
    (freq_sel == 2'h0) [*2]) else $error("selection not returned");
  pd_stop_a: assert property (pin_pd |-> want[2:1] == 2'h0) // RULE17
    else $error("outputs not stopped in power-down");
  stop_low_a: assert property ($rose(out_r[0]) |-> $past(run_r[0])) // RULE21
    else $error("output started while stopped");
  gate_one_a: assert property (fn == cc_pkg::CC_FN_OUT_EN && // RULE16
    $changed(mf_pin_i) && $stable(cfg_r) |-> $stable(want[2:1]))
    else $error("enable pin touched other outputs");
endmodule
`default_nettype wire

// ### rtl/cc_regs.svh
// Constants of the clock output select and control block.
// Assumes a single 20 MHz system clock; included by bare name.
`ifndef CC_REGS_SVH
`define CC_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define CC_CLK_HZ         20000000
`define CC_CYC_PER_MS     (`CC_CLK_HZ / 1000)
`define CC_TMO_SEL0_MS    500
`define CC_TMO_SEL1_MS    1000
`define CC_TMO_SEL2_MS    2000
`define CC_TMO_SEL3_MS    4000
`define CC_RST_PULSE_MS   250
`define CC_SLEW_DIV       16
`define CC_SLEW_STEP      32'h0000_0100

// ****************************************
// Output dividers
// ****************************************
`define CC_DIV_SE_THIRD_PLL    3'h5
`define CC_DIV_SE_SECOND_PLL    3'h4
`define CC_DIV_SE_REF     3'h4
`define CC_DIV_SE_OSC     3'h1
`define CC_DIV_DIFF_FIRST_PLL  3'h1
`define CC_DIV_DIFF_SECOND_PLL  3'h3
`define CC_DIV_DIFF_REF   3'h1

// ****************************************
// Select codes and resets
// ****************************************
`define CC_SE_OSC32K      4'h4
`define CC_SE_THIRD_PLL        4'h8
`define CC_SE_SECOND_PLL        4'he
`define CC_SE_REF         4'hd
`define CC_SETTING_RST    32'h0000_0000

`endif

// ### rtl/cc_pkg.sv
// Types of the clock output select and control block.
// Assumes cc_regs.svh supplies all numeric constants.
`default_nettype none
package cc_pkg;

  typedef enum logic [1:0] {
    CC_FN_OUT_EN  = 2'b00,
    CC_FN_PWRDN   = 2'b01,
    CC_FN_MONITOR = 2'b10,
    CC_FN_FSEL    = 2'b11
  } cc_pin_fn_t;

  typedef enum logic [1:0] {
    CC_PWR_FULL  = 2'b00,
    CC_PWR_PIN   = 2'b01,
    CC_PWR_REG   = 2'b10,
    CC_PWR_ULTRA = 2'b11
  } cc_pwr_t;

  typedef enum logic [2:0] {
    CC_SRC_NONE = 3'b000,
    CC_SRC_OSC  = 3'b001,
    CC_SRC_FIRST_PLL = 3'b010,
    CC_SRC_SECOND_PLL = 3'b011,
    CC_SRC_THIRD_PLL = 3'b100,
    CC_SRC_REF  = 3'b101
  } cc_src_t;

  // One-cycle ticks, one per half period of each source
  typedef struct packed {
    logic osc32k;
    logic first_pll;
    logic second_pll;
    logic third_pll;
    logic ref_clk;
  } cc_ticks_t;

  typedef struct packed {
    logic [3:0] se_sel;
    logic       diff_a_second_pll;
    logic       diff_b_second_pll;
    logic       diff_ref;
    logic       freq_control_enable;
    cc_pin_fn_t enable_pin_function_field;
    logic       reset_pin_sel;
    logic       reset_ctl_en;
    logic       i2c_oe_en;
    logic [2:0] out_en;
    logic       reg_powerdown;
    logic       ultra_powerdown;
    logic       timer_en;
    logic [1:0] timer_sel;
    logic [1:0] freq_sel_reg;
    logic [1:0] cfg_index;
  } cc_cfg_t;

endpackage
`default_nettype wire

// ### rtl/cc_setting_mem.sv
// Four stored feedback divider settings of the second PLL.
// Assumes one write port and a registered read port on clk.
`default_nettype none
`include "cc_regs.svh"
module cc_setting_mem #(
  parameter int W     = 32,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= W'(`CC_SETTING_RST);
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= W'(`CC_SETTING_RST);
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// ### testbench/cc_src_model.sv
// Source clock model: periodic one-cycle ticks for every source.
// Assumes the clk and rst of the block under test.
`default_nettype none
module cc_src_model (
  input  wire logic         clk,
  input  wire logic         rst,
  output cc_pkg::cc_ticks_t ticks
);
  timeunit 1ns;
  timeprecision 1ns;
  // Periods in cycles: ref, third_pll, second_pll, first_pll, osc32k
  // Distinct periods make every source and divider pair unique
  localparam int PER [5] = '{4, 1, 3, 2, 7};
  logic [2:0] cnt_r [5];
  logic [4:0] tk;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      tk[i] = (cnt_r[i] == 3'h0);
    end
  end
  assign ticks = tk;
  always_ff @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (rst || cnt_r[i] == 3'(PER[i] - 1)) begin
        cnt_r[i] <= 3'h0;
      end else begin
        cnt_r[i] <= cnt_r[i] + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/clock_output_select_control_tb.sv
// Bench of the clock control block: sources, gating, selection,
// setting slew and timer.
// Assumes cc_src_model gives the source ticks.
`default_nettype none
module clock_output_select_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPM = 20;
  typedef struct {
    logic [3:0] se;
    logic [2:0] dif;
    logic [1:0] fn;
    logic       pin;
    logic [2:0] pd;
    int         h [3];
  } cc_row_t;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  cc_pkg::cc_cfg_t   cfg = '0;
  logic              stp = 1'b0;
  logic              vwr = 1'b0;
  logic [31:0]       vdat = 32'h0;
  cc_pkg::cc_ticks_t tk;
  logic              pin = 1'b1;
  logic              scl = 1'b1;
  logic              sda = 1'b0;
  logic              se, da, db, tflag, pin_o, pin_oe, i2c_act, slew;
  logic [1:0]        fsel;
  logic [31:0]       vset;
  cc_pkg::cc_pwr_t   pwr;
  int                bad_count = 0;
  int                n_compared = 0;
  // dif: a_second_pll, b_second_pll, ref; pd: i2c_oe_en, reg pd, ultra pd
  cc_row_t rows [11] = '{
    '{4'h4, 3'b000, 2'b00, 1'b1, 3'b100, '{7, 2, 2}},
    '{4'h8, 3'b100, 2'b00, 1'b1, 3'b100, '{5, 9, 2}},
    '{4'he, 3'b010, 2'b00, 1'b1, 3'b100, '{12, 2, 9}},
    '{4'hd, 3'b001, 2'b00, 1'b1, 3'b100, '{16, 4, 4}},
    '{4'hd, 3'b000, 2'b00, 1'b0, 3'b100, '{0, 2, 2}},
    '{4'h4, 3'b000, 2'b01, 1'b0, 3'b100, '{7, 0, 0}},
    '{4'hd, 3'b000, 2'b10, 1'b0, 3'b100, '{7, 2, 2}},
    '{4'hd, 3'b000, 2'b10, 1'b1, 3'b100, '{16, 2, 2}},
    '{4'hd, 3'b000, 2'b00, 1'b1, 3'b000, '{0, 0, 0}},
    '{4'hd, 3'b000, 2'b00, 1'b1, 3'b110, '{0, 0, 0}},
    '{4'hd, 3'b000, 2'b00, 1'b1, 3'b101, '{0, 0, 0}}
  };

  always #25 clk = ~clk;

  cc_src_model cc_src_model_i (.clk(clk), .rst(rst), .ticks(tk));
  cc_clock_ctrl #(.CYC_PER_MS(CPM)) cc_clock_ctrl_i (
    .clk(clk), .rst(rst), .cfg_stage(cfg), .cfg_stop(stp),
    .vco_wr(vwr), .vco_wdata(vdat), .src_ticks(tk), .mf_pin_i(pin),
    .mf_pin_o(pin_o), .mf_pin_oe(pin_oe), .scl_i(scl), .sda_i(sda),
    .single_ended_output(se), .differential_output_a(da),
    .differential_output_b(db), .timeout_flag(tflag),
    .pwr_state(pwr), .i2c_active(i2c_act), .freq_sel(fsel),
    .vco_setting(vset), .slewing(slew));

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic outv(input int k);
    return k == 0 ? se : (k == 1 ? da : db);
  endfunction

  task automatic apply();
    @(negedge clk);
    stp = 1'b1;
    @(negedge clk);
    stp = 1'b0;
  endtask

  // Half period from the third toggle; 0 when the output stands still
  task automatic measure(input int k, output int half);
    logic v;
    int   n;
    half = 0;
    for (int t = 0; t < 3; t++) begin
      v = outv(k);
      n = 0;
      while (outv(k) === v && n < 80) begin
        @(negedge clk);
        n++;
      end
      if (n >= 80) return;
      half = n;
    end
  endtask

  task automatic span(input int k, input int lim, output int n);
    n = 0;
    while ((k == 0 ? tflag !== 1'b1 : pin_o === 1'b1) && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input int tol);
    n_compared++;
    if (got < exp - tol || got > exp + tol) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Counts: compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #(90000 * 50);
    bad_count++;
    end_sim();
  end

  initial begin
    int h;
    int n;
    logic ovs;
    logic [31:0] ep;
    cfg.i2c_oe_en = 1'b1;
    cfg.out_en = 3'b111;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_val({se, da, db, tflag, pin_oe, fsel}, 32'h0);
    chk_val(vset, 32'h0);
    $display("Test reset done");
    foreach (rows[r]) begin
      cfg.se_sel = rows[r].se;
      {cfg.diff_a_second_pll, cfg.diff_b_second_pll, cfg.diff_ref} = rows[r].dif;
      cfg.enable_pin_function_field = cc_pkg::cc_pin_fn_t'(rows[r].fn);
      {cfg.i2c_oe_en, cfg.reg_powerdown, cfg.ultra_powerdown} = rows[r].pd;
      pin = rows[r].pin;
      apply();
      repeat (40) @(negedge clk);
      chk_val(i2c_act, {31'h0, ~rows[r].pd[0]});
      ep = rows[r].pd[0] ? 32'h3 : (rows[r].pd[1] ? 32'h2 : 32'h0);
      if (ep == 32'h0 && rows[r].fn == 2'b01 && !rows[r].pin) ep = 32'h1;
      chk_val(32'(pwr), ep);
      for (int k = 0; k < 3; k++) begin
        measure(k, h);
        chk_cnt(h, rows[r].h[k], 0);
        chk_val(rows[r].h[k] == 0 ? outv(k) : 1'b0, 32'h0);
      end
    end
    $display("Test rows done");
    cfg.ultra_powerdown = 1'b0;
    cfg.se_sel = 4'h8;
    apply();
    cfg.se_sel = 4'he;
    repeat (40) @(negedge clk);
    measure(0, h);
    chk_cnt(h, 5, 0);
    apply();
    repeat (40) @(negedge clk);
    measure(0, h);
    chk_cnt(h, 12, 0);
    $display("Test staging done");
    cfg.enable_pin_function_field = cc_pkg::CC_FN_FSEL;
    cfg.freq_sel_reg = 2'h3;
    apply();
    chk_val(fsel, 32'h0);
    cfg.freq_control_enable = 1'b1;
    apply();
    chk_val(fsel, 32'h1);
    cfg.enable_pin_function_field = cc_pkg::CC_FN_OUT_EN;
    apply();
    chk_val(fsel, 32'h3);
    $display("Test select done");
    cfg.freq_sel_reg = 2'h0;
    cfg.cfg_index = 2'h2;
    apply();
    vdat = 32'h0000_0a00;
    vwr = 1'b1;
    @(negedge clk);
    vwr = 1'b0;
    apply();
    cfg.freq_sel_reg = 2'h2;
    apply();
    n = 0;
    ovs = 1'b0;
    while (vset !== 32'h0000_0a00 && n < 400) begin
      @(negedge clk);
      n++;
      ovs |= (vset > 32'h0000_0a00);
    end
    chk_cnt(n, 160, 20);
    chk_val(ovs, 32'h0);
    chk_val(slew, 32'h0);
    $display("Test slew done");
    {cfg.timer_en, cfg.reset_ctl_en, cfg.reset_pin_sel} = 3'b111;
    apply();
    span(0, 12000, n);
    chk_cnt(n, 500 * CPM, 25);
    chk_val(fsel, 32'h0);
    @(negedge clk);
    chk_val(pin_oe, 32'h1);
    span(1, 6000, n);
    chk_cnt(n, 250 * CPM, 25);
    {cfg.timer_en, cfg.freq_control_enable} = 2'b00;
    apply();
    @(negedge clk);
    chk_val(tflag, 32'h0);
    {cfg.timer_en, cfg.reset_ctl_en, cfg.reset_pin_sel} = 3'b100;
    cfg.timer_sel = 2'h1;
    apply();
    span(0, 22000, n);
    chk_cnt(n, 1000 * CPM, 25);
    chk_val(pin_oe, 32'h0);
    $display("Test timer done");
    scl = 1'b0;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    {cfg.timer_en, cfg.freq_control_enable} = 2'b01;
    apply();
    for (int v = 0; v < 4; v++) begin
      {scl, sda} = 2'(v);
      @(negedge clk);
      chk_val(fsel, 32'(v));
    end
    $display("Test strap done");
    end_sim();
  end
endmodule
`default_nettype wire
